//--- lvp_regs.sv
// Linefeed voltage and power register bank with APB slave port.
// Assumes the analog loop supplies per-transistor power codes and line state.
//
// Operation
// - Bit 6 of on-hook register picks polarity: 0 positive, 1 negative.
// - On-hook magnitude is six bits, 1.5 V per code from zero.
// - Common mode drives tip when forward, ring when reverse, in active/on-hook.
// - Common mode is six bits, zero down to most negative, 1.5 V steps.
// - High battery is six bits, negative 1.5 V steps, resets to -75 V.
// - Low battery is six bits, negative 1.5 V steps, resets to -24 V.
// - Pointer codes 0 to 5 pick transistors one to six; 6, 7 undefined.
// - Read-only power byte of selected transistor; 30.4 mW steps for 1,2,5,6.
// - Transistors three and four report power in 3.62 mW steps.
// - Manual differential control makes line follow the on-hook setting.
//
// Implementation choice: the APB slave port.
`timescale 1ns/100ps

module lvp_regs
    import lvp_pkg::*;
(
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic [ADDR_W-1:0]            paddr,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [31:0]                  pwdata,
    output logic                              pready,
    output logic [31:0]                       prdata,
    output logic                              pslverr,
    input  wire logic [NUM_XTOR-1:0][PWR_W-1:0] xtor_power,
    input  wire logic                         reverse_state,
    input  wire logic                         cm_feed_state,
    input  wire logic                         diff_manual_ctrl,
    input  wire lvp_diff_t                    auto_diff_target,
    output lvp_line_cfg_t                     line_cfg,
    output lvp_diff_t                         diff_target,
    output logic [MAG_W-1:0]                  tip_cm_target,
    output logic                              tip_cm_en,
    output logic [MAG_W-1:0]                  ring_cm_target,
    output logic                              ring_cm_en,
    output lvp_scale_t                        readout_scale,
    output logic                              pointer_valid,
    output logic                              battery_order_err
);

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [2:0]       power_monitor_pointer;
    logic [PWR_W-1:0] power_readout_value;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    // Setup phase is the cycle the request is first seen
    wire setup_phase = psel & ~penable;
    wire access_done = psel & penable & pready;
    wire wr_commit   = access_done & pwrite;

    wire hit_on_hook  = (paddr == ADDR_ON_HOOK);
    wire hit_common   = (paddr == ADDR_COMMON);
    wire hit_high     = (paddr == ADDR_HIGH_BATT);
    wire hit_low      = (paddr == ADDR_LOW_BATT);
    wire hit_select   = (paddr == ADDR_PWR_SELECT);
    wire hit_read     = (paddr == ADDR_PWR_READ);
    wire addr_mapped  = hit_on_hook | hit_common | hit_high | hit_low | hit_select | hit_read;

    wire wr_on_hook = wr_commit & hit_on_hook;
    wire wr_common  = wr_commit & hit_common;
    wire wr_high    = wr_commit & hit_high;
    wire wr_low     = wr_commit & hit_low;
    wire wr_select  = wr_commit & hit_select;

    // Read mux; reserved bits are constant zero
    wire [31:0] rd_on_hook = {25'h0, line_cfg.line_polarity_sel, line_cfg.onhook_diff_setting};
    wire [31:0] rd_common  = {26'h0, line_cfg.common_mode_setting};
    wire [31:0] rd_high    = {26'h0, line_cfg.high_batt_setting};
    wire [31:0] rd_low     = {26'h0, line_cfg.low_batt_setting};
    wire [31:0] rd_select  = {29'h0, power_monitor_pointer};
    wire [31:0] rd_read    = {24'h0, power_readout_value};

    wire [31:0] next_prdata = hit_on_hook ? rd_on_hook :
                              hit_common  ? rd_common  :
                              hit_high    ? rd_high    :
                              hit_low     ? rd_low     :
                              hit_select  ? rd_select  :
                              hit_read    ? rd_read    : 32'h0;

    // Answer in the cycle after setup: no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_phase;
            prdata  <= (setup_phase & ~pwrite) ? next_prdata : 32'h0;
            pslverr <= setup_phase & ~addr_mapped;
        end
    end

    // ----------------------------------------------------------------
    // Writable settings
    // ----------------------------------------------------------------
    // Only the defined low bits are stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_cfg.line_polarity_sel   <= RST_ON_HOOK[POL_BIT];
            line_cfg.onhook_diff_setting <= RST_ON_HOOK[MAG_W-1:0];
            line_cfg.common_mode_setting <= RST_COMMON[MAG_W-1:0];
            line_cfg.high_batt_setting   <= RST_HIGH_BATT[MAG_W-1:0];
            line_cfg.low_batt_setting    <= RST_LOW_BATT[MAG_W-1:0];
            power_monitor_pointer        <= RST_PWR_SELECT[PTR_W-1:0];
        end else begin
            if (wr_on_hook) begin
                line_cfg.line_polarity_sel   <= pwdata[POL_BIT];
                line_cfg.onhook_diff_setting <= pwdata[MAG_W-1:0];
            end
            if (wr_common) begin
                line_cfg.common_mode_setting <= pwdata[MAG_W-1:0];
            end
            if (wr_high) begin
                line_cfg.high_batt_setting <= pwdata[MAG_W-1:0];
            end
            if (wr_low) begin
                line_cfg.low_batt_setting <= pwdata[MAG_W-1:0];
            end
            if (wr_select) begin
                power_monitor_pointer <= pwdata[PTR_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Power monitor selection
    // ----------------------------------------------------------------
    logic [NUM_XTOR-1:0][PWR_W-1:0] masked_power;
    logic [PWR_W-1:0]               next_readout;

    // One masked lane per transistor
    genvar gi;
    generate
        for (gi = 0; gi < NUM_XTOR; gi = gi + 1) begin : g_lane
            assign masked_power[gi] = (power_monitor_pointer == 3'(gi)) ? xtor_power[gi] : '0;
        end
    endgenerate

    // Undefined pointer codes read zero
    always_comb begin
        next_readout = '0;
        for (int i = 0; i < NUM_XTOR; i++) begin
            next_readout = next_readout | masked_power[i];
        end
    end

    wire        next_ptr_valid = (power_monitor_pointer <= PTR_LAST);
    wire        fine_sel       = (power_monitor_pointer == PTR_Q3) | (power_monitor_pointer == PTR_Q4);
    lvp_scale_t next_scale;
    assign next_scale = fine_sel ? SCALE_FINE : SCALE_COARSE;

    // Real-time readout and its step size
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_readout_value <= RST_PWR_READ;
            readout_scale       <= SCALE_COARSE;
            pointer_valid       <= 1'b0;
        end else begin
            power_readout_value <= next_readout;
            readout_scale       <= next_scale;
            pointer_valid       <= next_ptr_valid;
        end
    end

    // ----------------------------------------------------------------
    // Loop targets
    // ----------------------------------------------------------------
    lvp_diff_t onhook_diff;
    assign onhook_diff = '{negative: line_cfg.line_polarity_sel, magnitude: line_cfg.onhook_diff_setting};

    lvp_diff_t next_diff_target;
    assign next_diff_target = diff_manual_ctrl ? onhook_diff : auto_diff_target;

    wire next_tip_en  = cm_feed_state & ~reverse_state;
    wire next_ring_en = cm_feed_state & reverse_state;
    wire next_order_err = (line_cfg.high_batt_setting < line_cfg.low_batt_setting);

    // Differential and common-mode targets toward the loop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            diff_target       <= '0;
            tip_cm_target     <= '0;
            tip_cm_en         <= 1'b0;
            ring_cm_target    <= '0;
            ring_cm_en        <= 1'b0;
            battery_order_err <= 1'b0;
        end else begin
            diff_target       <= next_diff_target;
            tip_cm_en         <= next_tip_en;
            ring_cm_en        <= next_ring_en;
            tip_cm_target     <= next_tip_en ? line_cfg.common_mode_setting : '0;
            ring_cm_target    <= next_ring_en ? line_cfg.common_mode_setting : '0;
            battery_order_err <= next_order_err;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_write(logic [11:0] a);
        psel && penable && pready && pwrite && paddr == a;
    endsequence

    // Completed read of one register
    sequence s_read(logic [11:0] a);
        psel && penable && pready && !pwrite && paddr == a;
    endsequence

    // Pointer left on one code for two edges
    sequence s_ptr_held(logic [2:0] p);
        power_monitor_pointer == p ##1 power_monitor_pointer == p;
    endsequence

    a_polarity_write: assert property (s_write(ADDR_ON_HOOK) |=>
        line_cfg.line_polarity_sel == $past(pwdata[POL_BIT]))
        else $error("polarity bit not taken from bit 6");

    a_onhook_mag_write: assert property (s_write(ADDR_ON_HOOK) |=>
        line_cfg.onhook_diff_setting == $past(pwdata[MAG_W-1:0]))
        else $error("on-hook magnitude not stored");

    a_cm_steering: assert property (cm_feed_state && !reverse_state |=>
        tip_cm_en && !ring_cm_en && tip_cm_target == $past(line_cfg.common_mode_setting))
        else $error("forward state did not steer common mode to tip");

    a_cm_reverse: assert property (cm_feed_state && reverse_state |=>
        ring_cm_en && !tip_cm_en && ring_cm_target == $past(line_cfg.common_mode_setting))
        else $error("reverse state did not steer common mode to ring");

    a_cm_hold: assert property (!(psel && penable && pwrite && hit_common) |=>
        $stable(line_cfg.common_mode_setting))
        else $error("common mode changed without a write");

    a_high_batt_rst: assert property ($rose(presetn) |->
        line_cfg.high_batt_setting == RST_HIGH_BATT[MAG_W-1:0])
        else $error("high battery reset value wrong");

    a_low_batt_rst: assert property ($rose(presetn) |->
        line_cfg.low_batt_setting == RST_LOW_BATT[MAG_W-1:0])
        else $error("low battery reset value wrong");

    a_ptr_undef_zero: assert property (power_monitor_pointer > PTR_LAST |=>
        power_readout_value == 8'h00 && !pointer_valid)
        else $error("undefined pointer gave a reading");

    a_readout_track: assert property (power_monitor_pointer == 3'h0 ##1 $stable(power_monitor_pointer) |->
        power_readout_value == $past(xtor_power[0]))
        else $error("readout does not follow transistor one");

    a_fine_scale: assert property (fine_sel |=> readout_scale == SCALE_FINE)
        else $error("transistor three or four not on fine scale");

    a_manual_diff: assert property (diff_manual_ctrl |=>
        diff_target == $past(onhook_diff))
        else $error("manual mode did not follow on-hook setting");

    a_reserved_zero: assert property (pready && psel && penable && !pwrite && hit_select |->
        prdata[31:3] == 29'h0)
        else $error("reserved pointer bits read nonzero");

    a_cm_write: assert property (s_write(ADDR_COMMON) |=>
        line_cfg.common_mode_setting == $past(pwdata[MAG_W-1:0]))
        else $error("common mode write not stored");

    a_high_batt_write: assert property (s_write(ADDR_HIGH_BATT) |=>
        line_cfg.high_batt_setting == $past(pwdata[MAG_W-1:0]))
        else $error("high battery write not stored");

    a_low_batt_write: assert property (s_write(ADDR_LOW_BATT) |=>
        line_cfg.low_batt_setting == $past(pwdata[MAG_W-1:0]))
        else $error("low battery write not stored");

    a_cm_idle: assert property (!cm_feed_state |=>
        !tip_cm_en && !ring_cm_en && tip_cm_target == '0 && ring_cm_target == '0)
        else $error("common mode applied outside feed states");

    a_ptr_write: assert property (s_write(ADDR_PWR_SELECT) |=>
        power_monitor_pointer == $past(pwdata[PTR_W-1:0]))
        else $error("pointer write not stored");

    a_ptr_valid: assert property (presetn && power_monitor_pointer <= PTR_LAST |=> pointer_valid)
        else $error("defined pointer code not flagged valid");

    a_coarse_scale: assert property (!fine_sel |=> readout_scale == SCALE_COARSE)
        else $error("coarse transistor not on coarse scale");

    a_readout_fine: assert property (s_ptr_held(PTR_Q3) |->
        power_readout_value == $past(xtor_power[PTR_Q3]))
        else $error("readout does not follow transistor three");

    a_auto_diff: assert property (!diff_manual_ctrl |=>
        diff_target == $past(auto_diff_target))
        else $error("automatic mode did not follow loop target");

    a_reserved_onhook: assert property (s_read(ADDR_ON_HOOK) |-> prdata[31:7] == 25'h0)
        else $error("reserved on-hook bit read nonzero");

    a_reserved_common: assert property (s_read(ADDR_COMMON) |-> prdata[31:6] == 26'h0)
        else $error("reserved common mode bits read nonzero");

endmodule

//--- lvp_pkg.sv
// Constants and carrier types for the linefeed voltage and power register bank.
// Assumes a 32-bit APB slave port; each register sits in one aligned word.
package lvp_pkg;

    // ----------------------------------------------------------------
    // Register indices and byte addresses (byte address = 4 * index)
    // ----------------------------------------------------------------
    localparam logic [7:0]  IDX_ON_HOOK    = 8'h48;
    localparam logic [7:0]  IDX_COMMON     = 8'h49;
    localparam logic [7:0]  IDX_HIGH_BATT  = 8'h4a;
    localparam logic [7:0]  IDX_LOW_BATT   = 8'h4b;
    localparam logic [7:0]  IDX_PWR_SELECT = 8'h4c;
    localparam logic [7:0]  IDX_PWR_READ   = 8'h4d;
    localparam int          ADDR_W         = 12;
    localparam logic [11:0] ADDR_ON_HOOK    = {2'h0, IDX_ON_HOOK, 2'h0};
    localparam logic [11:0] ADDR_COMMON     = {2'h0, IDX_COMMON, 2'h0};
    localparam logic [11:0] ADDR_HIGH_BATT  = {2'h0, IDX_HIGH_BATT, 2'h0};
    localparam logic [11:0] ADDR_LOW_BATT   = {2'h0, IDX_LOW_BATT, 2'h0};
    localparam logic [11:0] ADDR_PWR_SELECT = {2'h0, IDX_PWR_SELECT, 2'h0};
    localparam logic [11:0] ADDR_PWR_READ   = {2'h0, IDX_PWR_READ, 2'h0};

    // ----------------------------------------------------------------
    // Field positions and widths
    // ----------------------------------------------------------------
    localparam int POL_BIT   = 6;
    localparam int MAG_W     = 6;
    localparam int PTR_W     = 3;
    localparam int PWR_W     = 8;
    localparam int NUM_XTOR  = 6;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_ON_HOOK    = 8'h20;
    localparam logic [7:0] RST_COMMON     = 8'h02;
    localparam logic [7:0] RST_HIGH_BATT  = 8'h32;
    localparam logic [7:0] RST_LOW_BATT   = 8'h10;
    localparam logic [7:0] RST_PWR_SELECT = 8'h00;
    localparam logic [7:0] RST_PWR_READ   = 8'h00;

    // ----------------------------------------------------------------
    // Pointer codes
    // ----------------------------------------------------------------
    localparam logic [2:0] PTR_Q3   = 3'h2;
    localparam logic [2:0] PTR_Q4   = 3'h3;
    localparam logic [2:0] PTR_LAST = 3'h5;

    // Readout step size: coarse 30.4 mW, fine 3.62 mW
    typedef enum logic [0:0] {
        SCALE_COARSE = 1'b0,
        SCALE_FINE   = 1'b1
    } lvp_scale_t;

    // Settings handed to the analog loop
    typedef struct packed {
        logic             line_polarity_sel;
        logic [MAG_W-1:0] onhook_diff_setting;
        logic [MAG_W-1:0] common_mode_setting;
        logic [MAG_W-1:0] high_batt_setting;
        logic [MAG_W-1:0] low_batt_setting;
    } lvp_line_cfg_t;

    // Signed differential target: polarity plus magnitude
    typedef struct packed {
        logic             negative;
        logic [MAG_W-1:0] magnitude;
    } lvp_diff_t;

endpackage

//--- lvp_regs_tb.sv
// Self-checking testbench for the linefeed voltage and power register bank.
// Assumes lvp_pkg and lvp_regs are compiled first; the bench alone drives every port.
`timescale 1ns/100ps

module lvp_regs_tb
    import lvp_pkg::*;
;
    logic                         pclk;
    logic                         presetn;
    logic [ADDR_W-1:0]            paddr;
    logic                         psel;
    logic                         penable;
    logic                         pwrite;
    logic [31:0]                  pwdata;
    logic                         pready;
    logic [31:0]                  prdata;
    logic                         pslverr;
    logic [NUM_XTOR-1:0][PWR_W-1:0] xtor_power;
    logic                         reverse_state;
    logic                         cm_feed_state;
    logic                         diff_manual_ctrl;
    lvp_diff_t                    auto_diff_target;
    lvp_line_cfg_t                line_cfg;
    lvp_diff_t                    diff_target;
    logic [MAG_W-1:0]             tip_cm_target;
    logic                         tip_cm_en;
    logic [MAG_W-1:0]             ring_cm_target;
    logic                         ring_cm_en;
    lvp_scale_t                   readout_scale;
    logic                         pointer_valid;
    logic                         battery_order_err;
    int                           failures;
    int                           cmp_count;

    lvp_regs lvp_regs_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .xtor_power(xtor_power), .reverse_state(reverse_state), .cm_feed_state(cm_feed_state),
        .diff_manual_ctrl(diff_manual_ctrl), .auto_diff_target(auto_diff_target), .line_cfg(line_cfg),
        .diff_target(diff_target), .tip_cm_target(tip_cm_target), .tip_cm_en(tip_cm_en),
        .ring_cm_target(ring_cm_target), .ring_cm_en(ring_cm_en), .readout_scale(readout_scale),
        .pointer_valid(pointer_valid), .battery_order_err(battery_order_err));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    // Counts, verdict and end of run
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One comparison, reported at once on mismatch
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // APB transfer: setup, access until pready, release after that edge
    task automatic apb(input logic [11:0] addr, input logic wr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= addr;
        pwrite  <= wr;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                break;
            end
        end
        if (n == 20) begin
            failures++;
            $display("mismatch at %0t: pready never came", $time);
            test_done();
        end else begin
            rd = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // Register write, error flag expected low
    task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
        logic [31:0] rd;
        logic        err;
        apb(addr, 1'b1, wd, rd, err);
        chk(32'(err), 32'h0, "write error flag");
    endtask

    // Register read compared with an expected word and error flag
    task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic        err;
        apb(addr, 1'b0, 32'h0, rd, err);
        chk(rd, exp, "read data");
        chk(32'(err), 32'(exp_err), "read error flag");
    endtask

    // Let a loop-side input reach the registered outputs
    task automatic settle();
        repeat (2) @(posedge pclk);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Reset values of every register and of the settings carrier
    task automatic t_reset();
        rd_chk(ADDR_ON_HOOK, 32'h20, 1'b0);
        rd_chk(ADDR_COMMON, 32'h02, 1'b0);
        rd_chk(ADDR_HIGH_BATT, 32'h32, 1'b0);
        rd_chk(ADDR_LOW_BATT, 32'h10, 1'b0);
        rd_chk(ADDR_PWR_SELECT, 32'h00, 1'b0);
        rd_chk(ADDR_PWR_READ, 32'h00, 1'b0);
        chk(32'(line_cfg), 32'({1'b0, 6'h20, 6'h02, 6'h32, 6'h10}), "settings after reset");
        $display("test reset values done");
    endtask

    // Reserved bits, read-only readout, unmapped addresses
    task automatic t_fields();
        logic [31:0] rd;
        logic        err;
        wr(ADDR_ON_HOOK, 32'hffffffff);
        rd_chk(ADDR_ON_HOOK, 32'h7f, 1'b0);
        chk(32'(line_cfg.line_polarity_sel), 32'h1, "polarity bit");
        chk(32'(line_cfg.onhook_diff_setting), 32'h3f, "on-hook magnitude");
        wr(ADDR_COMMON, 32'hffffffc0);
        rd_chk(ADDR_COMMON, 32'h00, 1'b0);
        wr(ADDR_HIGH_BATT, 32'h000000ff);
        rd_chk(ADDR_HIGH_BATT, 32'h3f, 1'b0);
        wr(ADDR_LOW_BATT, 32'h000000ff);
        rd_chk(ADDR_LOW_BATT, 32'h3f, 1'b0);
        wr(ADDR_PWR_SELECT, 32'h000000f8);
        rd_chk(ADDR_PWR_SELECT, 32'h00, 1'b0);
        wr(ADDR_PWR_READ, 32'h000000ff);
        rd_chk(ADDR_PWR_READ, 32'h00, 1'b0);
        rd_chk(12'h000, 32'h0, 1'b1);
        apb(12'h138, 1'b1, 32'h5a, rd, err);
        chk(32'(err), 32'h1, "unmapped write error");
        $display("test field masks done");
    endtask

    // Every pointer code, readout value, scale and validity
    task automatic t_pointer();
        logic [7:0] exp;
        xtor_power <= {8'h66, 8'h55, 8'h44, 8'h33, 8'h22, 8'h11};
        for (int p = 0; p < 8; p++) begin
            wr(ADDR_PWR_SELECT, 32'(p));
            settle();
            exp = (p <= 5) ? 8'(8'h11 * (p + 1)) : 8'h00;
            chk(32'(readout_scale), 32'((p == 2) || (p == 3)), "readout scale");
            chk(32'(pointer_valid), 32'(p <= 5), "pointer valid");
            rd_chk(ADDR_PWR_READ, 32'(exp), 1'b0);
        end
        $display("test power pointer done");
    endtask

    // Common mode routed to tip or ring by line state
    task automatic t_cm();
        logic ten;
        logic ren;
        wr(ADDR_COMMON, 32'h2a);
        for (int i = 0; i < 4; i++) begin
            cm_feed_state <= i[0];
            reverse_state <= i[1];
            settle();
            ten = i[0] & ~i[1];
            ren = i[0] & i[1];
            chk(32'({ten, tip_cm_en}), 32'({ten, ten}), "tip enable");
            chk(32'(tip_cm_target), ten ? 32'h2a : 32'h0, "tip target");
            chk(32'({ren, ring_cm_en}), 32'({ren, ren}), "ring enable");
            chk(32'(ring_cm_target), ren ? 32'h2a : 32'h0, "ring target");
        end
        $display("test common mode done");
    endtask

    // Manual differential control against the automatic target
    task automatic t_diff();
        wr(ADDR_ON_HOOK, 32'h55);
        auto_diff_target <= '{negative: 1'b0, magnitude: 6'h3c};
        diff_manual_ctrl <= 1'b0;
        settle();
        chk(32'(diff_target), 32'h3c, "automatic target");
        diff_manual_ctrl <= 1'b1;
        settle();
        chk(32'(diff_target), 32'h55, "manual target");
        $display("test differential control done");
    endtask

    // Battery ordering flag at and across the boundary
    task automatic t_batt();
        wr(ADDR_HIGH_BATT, 32'h10);
        wr(ADDR_LOW_BATT, 32'h11);
        settle();
        chk(32'(battery_order_err), 32'h1, "order flag set");
        wr(ADDR_HIGH_BATT, 32'h11);
        settle();
        chk(32'(battery_order_err), 32'h0, "order flag clear");
        $display("test battery order done");
    endtask

    // ----------------------------------------------------------------
    // Clock, reset and main sequence
    // ----------------------------------------------------------------
    // Free-running 4 ns clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Reset, then each scenario in turn
    initial begin
        failures = 0;
        cmp_count = 0;
        presetn = 1'b0;
        paddr = '0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = '0;
        xtor_power = '0;
        reverse_state = 1'b0;
        cm_feed_state = 1'b0;
        diff_manual_ctrl = 1'b0;
        auto_diff_target = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_fields();
        t_pointer();
        t_cm();
        t_diff();
        t_batt();
        test_done();
    end

endmodule
